/* File: src/scsc_pkg.sv */
package scsc_pkg;

  // Register data width of each control and status word
  localparam int DATA_W = 16;
  // Strap group widths
  localparam int BASE_W = 10;
  localparam int VEC_W = 6;
  localparam int TRIB_W = 8;
  localparam int STRAP_W = 28;

  // Bus address layout: fixed top bits, base field, register select
  localparam logic [2:0] IOPAGE_TOP = 3'h7;
  localparam int ADR_TOP_LSB = 13;
  localparam int BASE_LSB = 3;
  localparam int REG_LSB = 1;
  // Vector bits sit above three fixed zero bits
  localparam logic [2:0] VEC_LOW = 3'h0;

  // Positions inside the packed strap vector
  localparam int STRAP_BASE_LSB = 0;
  localparam int STRAP_VEC_LSB = 10;
  localparam int STRAP_TRIB_LSB = 16;
  localparam int STRAP_MODESRC = 24;
  localparam int STRAP_SEL6 = 25;
  localparam int STRAP_SEL7 = 26;
  localparam int STRAP_SEL8 = 27;

  // Register word select within the four-word block
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_TRIB = 2'h2;
  localparam logic [1:0] REG_VECT = 2'h3;

  // Control word fields
  localparam int CTRL_HALF = 0;
  localparam int CTRL_SEL7 = 1;
  localparam int CTRL_P2P = 2;
  localparam int CTRL_INIT = 15;
  // Status word fields
  localparam int STAT_HALF = 0;
  localparam int STAT_COMPAT = 1;
  localparam int STAT_P2P = 2;
  localparam int STAT_CTRLST = 3;
  localparam int STAT_MODESW = 4;
  localparam int STAT_ADDRSW = 5;
  localparam int STAT_VALID = 6;

  // Reset values of the software-owned fields
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [7:0] TRIB_RESET = 8'h00;

  // Cycles the strap synchroniser needs before a sample is trusted
  localparam logic [1:0] SETTLE_CYC = 2'h2;

  // Decoded line and network mode
  typedef struct packed {
    logic halfDuplex;
    logic compatEn;
    logic pointToPoint;
    logic controlStation;
  } scsc_mode_type;

  // Initialisation sequencer states
  typedef enum logic [1:0] {
    INIT_SETTLE = 2'b00,
    INIT_SAMPLE = 2'b01,
    INIT_RUN = 2'b10
  } scsc_init_type;

  // Three mode selects, each 1 for a switch in the ON position
  function automatic scsc_mode_type decode_mode(input logic sel6, input logic sel7, input logic sel8);
    scsc_mode_type m;
    m.halfDuplex = sel6;
    m.pointToPoint = sel8;
    m.compatEn = sel8 & sel7;
    m.controlStation = ~sel8 & sel7;
    return m;
  endfunction

endpackage

/* File: src/scsc_cfg_if.sv */
`timescale 1ns/1ns
interface scsc_cfg_if;
  // Sampled configuration, held until the next initialisation
  logic valid;
  logic [9:0] base;
  logic [5:0] vec;
  logic [7:0] tribAddr;
  logic modeSw;
  logic [2:0] modeSel;

  modport provider (output valid, output base, output vec, output tribAddr, output modeSw, output modeSel);
  modport user (input valid, input base, input vec, input tribAddr, input modeSw, input modeSel);
endinterface

/* File: src/scsc_strap_latch.sv */
`timescale 1ns/1ns
module scsc_strap_latch (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Re-initialise request, one cycle
  input wire logic initReq,
  // Synchronised straps, 1 for a switch ON
  input wire logic [27:0] strapOn,
  // Sampled configuration
  scsc_cfg_if.provider cfg
);

  // Whole state of the sampler
  typedef struct packed {
    scsc_pkg::scsc_init_type fsm;
    logic [1:0] cnt;
    logic valid;
    logic [9:0] base;
    logic [5:0] vec;
    logic [7:0] tribAddr;
    logic modeSw;
    logic [2:0] modeSel;
  } scsc_latch_state_type;

  scsc_latch_state_type st_r;
  scsc_latch_state_type st_nxt;

  // Sequencer: settle, take one sample, then hold
  always_comb begin
    st_nxt = st_r;
    case (st_r.fsm)
      scsc_pkg::INIT_SETTLE: begin
        // Waits out the synchroniser so no stale pin level is caught
        if (st_r.cnt == scsc_pkg::SETTLE_CYC - 2'h1) begin
          st_nxt.fsm = scsc_pkg::INIT_SAMPLE;
        end else begin
          st_nxt.cnt = st_r.cnt + 2'h1;
        end
      end
      scsc_pkg::INIT_SAMPLE: begin
        // Every strap is caught in this single cycle
        st_nxt.base = strapOn[scsc_pkg::STRAP_BASE_LSB +: 10];
        st_nxt.vec = strapOn[scsc_pkg::STRAP_VEC_LSB +: 6];
        st_nxt.tribAddr = ~strapOn[scsc_pkg::STRAP_TRIB_LSB +: 8];
        // Switch 1 ON hands the mode to software
        st_nxt.modeSw = strapOn[scsc_pkg::STRAP_MODESRC];
        st_nxt.modeSel = {strapOn[scsc_pkg::STRAP_SEL8], strapOn[scsc_pkg::STRAP_SEL7], strapOn[scsc_pkg::STRAP_SEL6]};
        st_nxt.valid = 1'b1;
        st_nxt.fsm = scsc_pkg::INIT_RUN;
      end
      default: begin
        // Hold until the next initialisation
        st_nxt.fsm = scsc_pkg::INIT_RUN;
      end
    endcase
    // A new request restarts the sequence and hides the old sample
    if (initReq) begin
      st_nxt.fsm = scsc_pkg::INIT_SETTLE;
      st_nxt.cnt = 2'h0;
      st_nxt.valid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Drive the carrier
  assign cfg.valid = st_r.valid;
  assign cfg.base = st_r.base;
  assign cfg.vec = st_r.vec;
  assign cfg.tribAddr = st_r.tribAddr;
  assign cfg.modeSw = st_r.modeSw;
  assign cfg.modeSel = st_r.modeSel;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_init_hides: assert property (initReq |=> !st_r.valid [*3])
    else $error("sample valid too early after init");
  a_init_done: assert property (initReq ##1 (!initReq) [*3] |=> st_r.valid)
    else $error("sample not taken three cycles after init");
  a_trib_inverted: assert property ($rose(st_r.valid) |->
      st_r.tribAddr == ~$past(strapOn[23:16]) && st_r.base == $past(strapOn[9:0]))
    else $error("strap sense wrong on sample");
  a_sample_held: assert property (st_r.valid && !initReq |=>
      $stable(st_r.base) && $stable(st_r.modeSel) && $stable(st_r.tribAddr))
    else $error("sampled configuration changed while held");

endmodule

/* File: src/scsc_strap_config.sv */
`timescale 1ns/1ns
// How it works
// - Four 16-bit registers at strap-selected base
// - Base and vector straps: ON reads one
// - Tributary address from software or strap bank
// - Tributary straps read inverted: OFF gives one
// - Tributary straps all ON (reading all zero) mean software address
// - Switch 1 OFF: mode from straps; ON: software
// - Switch 6 ON half-duplex, OFF full-duplex
// - Switch 8 ON: point-to-point, 7 sets compatibility
// - Switch 8 OFF: multipoint, 7 picks control station
module scsc_strap_config (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Wishbone slave, 16-bit port, byte address
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [15:0] wbAdr,
  input wire logic [1:0] wbSel,
  input wire logic [15:0] wbDatWr,
  output logic [15:0] wbDatRd,
  output logic wbAck,
  // Board straps, 1 for a switch ON
  input wire logic [9:0] baseStrapOn,
  input wire logic [5:0] vecStrapOn,
  input wire logic [7:0] tribStrapOn,
  input wire logic modeSrcOn,
  input wire logic feat6On,
  input wire logic feat7On,
  input wire logic feat8On,
  // Configuration to the rest of the controller
  output logic halfDuplex,
  output logic compatEn,
  output logic pointToPoint,
  output logic controlStation,
  output logic [7:0] stationAddr,
  output logic stationAddrFromSw,
  output logic [8:0] intVector,
  output logic cfgValid
);

  // Whole state of the top
  typedef struct packed {
    logic [27:0] strapMeta;
    logic [27:0] strapSync;
    logic initReq;
    logic ack;
    logic [15:0] datRd;
    logic swHalf;
    logic swSel7;
    logic swP2p;
    logic [7:0] swTrib;
    scsc_pkg::scsc_mode_type mode;
    logic [7:0] stationAddr;
    logic addrFromSw;
    logic [8:0] vector;
    logic valid;
  } scsc_top_state_type;

  scsc_top_state_type st_r;
  scsc_top_state_type st_nxt;

  // Sampled configuration from the latch
  scsc_cfg_if cfg ();

  // Strap sampler, restarted by reset or a software init
  scsc_strap_latch scsc_strap_latch_i (
    .clk(clk),
    .srst(srst),
    .initReq(st_r.initReq),
    .strapOn(st_r.strapSync),
    .cfg(cfg.provider)
  );

  // Address hit: top page bits, strap base, no answer before a sample
  logic hit;
  logic [1:0] regSel;
  logic req;
  logic [15:0] rdMux;
  scsc_pkg::scsc_mode_type effMode;

  assign hit = (wbAdr[15:scsc_pkg::ADR_TOP_LSB] == scsc_pkg::IOPAGE_TOP)
    && (wbAdr[12:scsc_pkg::BASE_LSB] == cfg.base) && cfg.valid;
  assign regSel = wbAdr[scsc_pkg::REG_LSB +: 2];
  assign req = wbCyc && wbStb && hit;

  // Mode source: software bits or the sampled straps
  assign effMode = cfg.modeSw
    ? scsc_pkg::decode_mode(st_r.swHalf, st_r.swSel7, st_r.swP2p)
    : scsc_pkg::decode_mode(cfg.modeSel[0], cfg.modeSel[1], cfg.modeSel[2]);

  // Read data selection, from registered state only
  always_comb begin
    rdMux = 16'h0000;
    if (regSel == scsc_pkg::REG_CTRL) begin
      rdMux[scsc_pkg::CTRL_HALF] = st_r.swHalf;
      rdMux[scsc_pkg::CTRL_SEL7] = st_r.swSel7;
      rdMux[scsc_pkg::CTRL_P2P] = st_r.swP2p;
    end else if (regSel == scsc_pkg::REG_STAT) begin
      rdMux[scsc_pkg::STAT_HALF] = st_r.mode.halfDuplex;
      rdMux[scsc_pkg::STAT_COMPAT] = st_r.mode.compatEn;
      rdMux[scsc_pkg::STAT_P2P] = st_r.mode.pointToPoint;
      rdMux[scsc_pkg::STAT_CTRLST] = st_r.mode.controlStation;
      rdMux[scsc_pkg::STAT_MODESW] = cfg.modeSw;
      rdMux[scsc_pkg::STAT_ADDRSW] = st_r.addrFromSw;
      rdMux[scsc_pkg::STAT_VALID] = st_r.valid;
    end else if (regSel == scsc_pkg::REG_TRIB) begin
      // Effective station address, whichever source won
      rdMux[7:0] = st_r.stationAddr;
    end else begin
      rdMux[8:0] = st_r.vector;
    end
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchroniser for every strap pin
    st_nxt.strapMeta = {feat8On, feat7On, feat6On, modeSrcOn, tribStrapOn, vecStrapOn, baseStrapOn};
    st_nxt.strapSync = st_r.strapMeta;
    st_nxt.initReq = 1'b0;
    // One wait state: ack rises the cycle after the request, drops after one
    st_nxt.ack = req && !st_r.ack;
    if (req && !st_r.ack) begin
      st_nxt.datRd = rdMux;
    end
    // Writes land on the edge where the master sees ack
    if (req && st_r.ack && wbWe) begin
      if (regSel == scsc_pkg::REG_CTRL) begin
        if (wbSel[0]) begin
          st_nxt.swHalf = wbDatWr[scsc_pkg::CTRL_HALF];
          st_nxt.swSel7 = wbDatWr[scsc_pkg::CTRL_SEL7];
          st_nxt.swP2p = wbDatWr[scsc_pkg::CTRL_P2P];
        end
        // Init bit is a pulse; reads back as zero
        if (wbSel[1]) begin
          st_nxt.initReq = wbDatWr[scsc_pkg::CTRL_INIT];
        end
      end else if (regSel == scsc_pkg::REG_TRIB) begin
        // Stored always, used only when the straps read as all zero (all ON)
        if (wbSel[0]) begin
          st_nxt.swTrib = wbDatWr[7:0];
        end
      end
    end
    // Effective configuration, registered for clean outputs
    st_nxt.mode = effMode;
    st_nxt.addrFromSw = (cfg.tribAddr == 8'h00);
    st_nxt.stationAddr = (cfg.tribAddr == 8'h00) ? st_r.swTrib : cfg.tribAddr;
    st_nxt.vector = {cfg.vec, scsc_pkg::VEC_LOW};
    st_nxt.valid = cfg.valid;
  end

  // State register; reset also starts the first strap sample
  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.initReq <= 1'b1;
      st_r.swHalf <= scsc_pkg::CTRL_RESET[scsc_pkg::CTRL_HALF];
      st_r.swSel7 <= scsc_pkg::CTRL_RESET[scsc_pkg::CTRL_SEL7];
      st_r.swP2p <= scsc_pkg::CTRL_RESET[scsc_pkg::CTRL_P2P];
      st_r.swTrib <= scsc_pkg::TRIB_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign wbDatRd = st_r.datRd;
  assign wbAck = st_r.ack;
  assign halfDuplex = st_r.mode.halfDuplex;
  assign compatEn = st_r.mode.compatEn;
  assign pointToPoint = st_r.mode.pointToPoint;
  assign controlStation = st_r.mode.controlStation;
  assign stationAddr = st_r.stationAddr;
  assign stationAddrFromSw = st_r.addrFromSw;
  assign intVector = st_r.vector;
  assign cfgValid = st_r.valid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_no_foreign_ack: assert property (!(wbCyc && wbStb && hit) |=> !wbAck)
    else $error("ack for an address outside the block");
  a_ack_single: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  a_strap_duplex: assert property (cfg.valid && !cfg.modeSw |=> halfDuplex == $past(cfg.modeSel[0]))
    else $error("duplex does not follow switch 6");
  a_p2p_mode: assert property (cfg.valid && !cfg.modeSw && cfg.modeSel[2] |=>
      pointToPoint && !controlStation && compatEn == $past(cfg.modeSel[1]))
    else $error("point-to-point decode wrong");
  a_multi_mode: assert property (cfg.valid && !cfg.modeSw && !cfg.modeSel[2] |=>
      !pointToPoint && !compatEn && controlStation == $past(cfg.modeSel[1]))
    else $error("multipoint decode wrong");
  a_sw_mode: assert property (cfg.valid && cfg.modeSw |=>
      halfDuplex == $past(st_r.swHalf) && pointToPoint == $past(st_r.swP2p))
    else $error("software mode not applied");
  a_addr_source: assert property (cfg.valid && cfg.tribAddr == 8'h00 |=>
      stationAddrFromSw && stationAddr == $past(st_r.swTrib))
    else $error("zero straps did not select software address");
  a_addr_strap: assert property (cfg.valid && cfg.tribAddr != 8'h00 |=>
      !stationAddrFromSw && stationAddr == $past(cfg.tribAddr))
    else $error("strap station address not used");

  // Bus answer and read path, checked against the decode itself
  a_no_ack_unsampled: assert property (!cfg.valid |=> !wbAck)
    else $error("ack before the straps were sampled");
  a_ack_follows: assert property (wbCyc && wbStb && hit && !wbAck |=> wbAck)
    else $error("no ack one cycle after a matching request");
  a_read_vector: assert property (wbCyc && wbStb && hit && !wbAck && !wbWe && regSel == scsc_pkg::REG_VECT |=>
      wbDatRd == {7'h00, $past(intVector)})
    else $error("vector word read back wrong");
  // Vector keeps its low bits at zero whatever the straps say
  a_vector_map: assert property (cfg.valid |=> intVector == {$past(cfg.vec), scsc_pkg::VEC_LOW})
    else $error("vector does not follow its straps");

endmodule

/* File: verif/scsc_host_model.sv */
`timescale 1ns/1ns
module scsc_host_model (
  // Clock
  input wire logic clk,
  // Wishbone master side
  output logic wbCyc,
  output logic wbStb,
  output logic wbWe,
  output logic [15:0] wbAdr,
  output logic [1:0] wbSel,
  output logic [15:0] wbDatWr,
  // Slave answer
  input wire logic [15:0] wbDatRd,
  input wire logic wbAck
);
  // Idle bus at time zero
  initial begin
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 16'h0000;
    wbSel = 2'h3;
    wbDatWr = 16'h0000;
  end

  // One classic cycle, held until ack; a bound catches a silent slave
  task automatic access(input logic we, input logic [15:0] adr, input logic [15:0] dat,
                        output logic [15:0] rd, output logic acked);
    acked = 1'b0;
    rd = 16'h0000;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 2'h3;
    wbAdr <= adr;
    wbDatWr <= dat;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      // Ack seen at this edge, data taken here too
      if (wbAck === 1'b1) begin
        acked = 1'b1;
        rd = wbDatRd;
        break;
      end
    end
    // Release; stale lines flipped so nothing leans on old values
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    wbAdr <= ~adr;
    wbDatWr <= ~dat;
  endtask
endmodule

/* File: verif/scsc_strap_config_bench.sv */
`timescale 1ns/1ns
module scsc_strap_config_bench;
  // Clock, reset and bus
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wbCyc, wbStb, wbWe, wbAck;
  logic [15:0] wbAdr, wbDatWr, wbDatRd;
  logic [1:0] wbSel;
  // Board straps, 1 for ON; featOn is switches 8,7,6
  logic [9:0] baseStrapOn = 10'h001; // Lowest floating base
  logic [5:0] vecStrapOn = 6'h18;
  logic [7:0] tribStrapOn = 8'hF0; // Reads as station 0F, nonzero
  logic modeSrcOn = 1'b0;
  logic [2:0] featOn = 3'h0;
  // Configuration outputs
  logic halfDuplex, compatEn, pointToPoint, controlStation, stationAddrFromSw, cfgValid;
  logic [7:0] stationAddr;
  logic [8:0] intVector;
  // Tallies and scratch
  int failures = 0;
  int testsRun = 0;
  logic [15:0] rd;

  // 100 ns period
  always #50 clk = ~clk;

  scsc_strap_config scsc_strap_config_i (.clk(clk), .srst(srst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd), .wbAck(wbAck),
    .baseStrapOn(baseStrapOn), .vecStrapOn(vecStrapOn), .tribStrapOn(tribStrapOn), .modeSrcOn(modeSrcOn),
    .feat6On(featOn[0]), .feat7On(featOn[1]), .feat8On(featOn[2]), .halfDuplex(halfDuplex),
    .compatEn(compatEn), .pointToPoint(pointToPoint), .controlStation(controlStation),
    .stationAddr(stationAddr), .stationAddrFromSw(stationAddrFromSw), .intVector(intVector),
    .cfgValid(cfgValid));

  scsc_host_model scsc_host_model_i (.clk(clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatWr(wbDatWr), .wbDatRd(wbDatRd), .wbAck(wbAck));

  // Verdict and end of run
  task automatic print_verdict();
    $display("failures %0d comparisons %0d", failures, testsRun);
    if (failures == 0 && testsRun > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Value compare, four-state exact
  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for cfgValid to reach a level
  task automatic waitValid(input logic level);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (cfgValid === level)
        return;
    end
    failures++;
    print_verdict();
  endtask

  // Register access at word offset from the current base; ack presence checked
  task automatic bus(input logic we, input logic [1:0] word, input logic [15:0] dat, input logic expAck);
    logic acked;
    scsc_host_model_i.access(we, {3'h7, baseStrapOn, word, 1'b0}, dat, rd, acked);
    checkVal({15'h0000, acked}, {15'h0000, expAck});
  endtask

  // Software re-initialise, then wait for a fresh sample
  task automatic doInit();
    bus(1'b1, 2'h0, 16'h8000, 1'b1);
    waitValid(1'b0);
    waitValid(1'b1);
  endtask

  // Mode outputs against {half, compat, p2p, control}
  task automatic checkMode(input logic [3:0] exp);
    checkVal({12'h000, halfDuplex, compatEn, pointToPoint, controlStation}, {12'h000, exp});
  endtask

  // Straps read at reset: vector, station address, register block
  task automatic tStrapInit();
    checkVal({7'h00, intVector}, 16'h00C0);
    checkVal({8'h00, stationAddr}, 16'h000F);
    bus(1'b0, 2'h3, 16'h0000, 1'b1);
    checkVal(rd, 16'h00C0);
    bus(1'b0, 2'h1, 16'h0000, 1'b1);
    checkVal(rd, 16'h0040);
    bus(1'b0, 2'h2, 16'h0000, 1'b1);
    checkVal(rd, 16'h000F);
  endtask

  // Every mode switch setting, one init each
  task automatic tModeTable();
    for (int k = 0; k < 8; k++) begin
      featOn <= k[2:0];
      doInit();
      checkMode({k[0], k[2] & k[1], k[2], ~k[2] & k[1]});
    end
  endtask

  // Top of the floating range, top vector, decode refusals
  task automatic tDecode();
    logic acked;
    doInit();
    baseStrapOn <= 10'h0FF;
    vecStrapOn <= 6'h3F;
    doInit();
    scsc_host_model_i.access(1'b0, 16'hE008, 16'h0000, rd, acked);
    checkVal({15'h0000, acked}, 16'h0000);
    scsc_host_model_i.access(1'b0, 16'h67FE, 16'h0000, rd, acked);
    checkVal({15'h0000, acked}, 16'h0000);
    bus(1'b1, 2'h3, 16'h0000, 1'b1);
    bus(1'b0, 2'h3, 16'h0000, 1'b1);
    checkVal(rd, 16'h01F8);
  endtask

  // Software address and mode, then straps moved without init
  task automatic tSoftware();
    tribStrapOn <= 8'hFF;
    modeSrcOn <= 1'b1;
    doInit();
    checkVal({15'h0000, stationAddrFromSw}, 16'h0001);
    bus(1'b1, 2'h2, 16'h0042, 1'b1);
    bus(1'b1, 2'h0, 16'h0005, 1'b1);
    repeat (3) @(posedge clk);
    // Status: valid, address and mode from software, half, p2p
    bus(1'b0, 2'h1, 16'h0000, 1'b1);
    checkVal(rd, 16'h0075);
    bus(1'b0, 2'h0, 16'h0000, 1'b1);
    checkVal(rd, 16'h0005);
    bus(1'b0, 2'h2, 16'h0000, 1'b1);
    checkVal(rd, 16'h0042);
    checkVal({8'h00, stationAddr}, 16'h0042);
    checkMode(4'hA);
    featOn <= 3'h6;
    modeSrcOn <= 1'b0;
    tribStrapOn <= 8'h00;
    repeat (6) @(posedge clk);
    checkMode(4'hA);
    checkVal({8'h00, stationAddr}, 16'h0042);
  endtask

  // Main sequence: reset for 8 cycles, then the scenarios
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    waitValid(1'b1);
    tStrapInit();
    tModeTable();
    tDecode();
    tSoftware();
    print_verdict();
  end
endmodule
